// File: hdl/can_fd_error_status_report.sv
// APB error-flag and status register block of a CAN FD controller
//
// The APB register port is this design's own decision.
`timescale 1ns/1ps
module can_fd_error_status_report #(
  parameter bit non_iso_build_param = 1'b0
) (
  // Clock and reset
  input  wire logic                                  ref_clk,
  input  wire logic                                  rst,
  // APB slave
  input  wire logic                                  psel,
  input  wire logic                                  penable,
  input  wire logic                                  pwrite,
  input  wire logic [can_fd_err_pkg::ADDR_W-1:0]     paddr,
  input  wire logic [can_fd_err_pkg::DATA_W-1:0]     pwdata,
  input  wire logic [3:0]                            pstrb,
  output logic      [can_fd_err_pkg::DATA_W-1:0]     prdata,
  output logic                                       pready,
  output logic                                       pslverr,
  // Error detection pulses from the protocol engine
  input  wire logic                                  bit_err_det,
  input  wire logic                                  stuff_err_det,
  input  wire logic                                  form_err_det,
  input  wire logic                                  crc_err_det,
  input  wire logic                                  ack_err_det,
  // Error context
  input  wire logic                                  fast_phase,
  input  wire logic                                  tdc_phase,
  input  wire logic                                  fixed_stuff_bit,
  input  wire logic                                  crc_delim_err,
  // Controller state
  input  wire logic                                  config_mode,
  input  wire logic                                  normal_mode,
  input  wire logic                                  snoop_mode,
  input  wire logic                                  sleep_mode,
  input  wire logic                                  loopback_mode,
  input  wire logic                                  bus_busy_flag,
  input  wire logic                                  busoff_recovery_flag,
  input  wire logic                                  exception_integration_flag,
  input  wire logic                                  err_passive,
  input  wire logic                                  bus_off,
  input  wire logic [7:0]                            tx_err_count,
  input  wire logic [7:0]                            rx_err_count,
  input  wire logic [6:0]                            tx_delay_comp_offset,
  input  wire logic [6:0]                            tdc_measured_delay,
  // Flag view
  output logic      [31:0]                           bus_error_flags
);

  localparam logic [31:0] STATUS_RST_VAL = can_fd_err_pkg::STATUS_RST |
    (32'(non_iso_build_param) << can_fd_err_pkg::NON_ISO_FORMAT_FLAG_POS);

  logic [31:0] err_flags_ff;
  logic [31:0] status_ff;
  logic [31:0] prdata_ff;
  logic        pready_ff;
  logic        pslverr_ff;
  logic [31:0] err_set;
  logic [31:0] err_clr;
  logic [31:0] byte_mask;
  logic        access;
  logic        xfer_done;
  logic        hit_flags;
  logic        hit_status;
  logic        any_det;
  logic        stuff_as_form;
  logic        stuff_real;
  logic        form_any;
  logic        crc_real;
  logic [7:0]  tx_delay_comp_value_sum;
  logic [6:0]  tx_delay_comp_value;
  logic [1:0]  error_state_field;
  logic        warn;

  //////////////////////////////////////////////////////////////////////////
  // APB decode

  assign access     = psel & penable;
  assign xfer_done  = access & pready_ff;
  assign hit_flags  = (paddr == can_fd_err_pkg::ERR_FLAGS_OFS);
  assign hit_status = (paddr == can_fd_err_pkg::STATUS_OFS);

  // One wait state keeps every APB output registered
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      pready_ff <= 1'b0;
    end else begin
      pready_ff <= access & ~pready_ff;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      pslverr_ff <= 1'b0;
    end else if (access & ~pready_ff) begin
      pslverr_ff <= ~(hit_flags | hit_status);
    end else begin
      pslverr_ff <= 1'b0;
    end
  end

  // Read data masked so reserved bits read zero
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      prdata_ff <= 32'h0000_0000;
    end else if (access & ~pready_ff & ~pwrite) begin
      if (hit_flags) begin
        prdata_ff <= err_flags_ff & can_fd_err_pkg::ERR_FLAGS_MASK;
      end else if (hit_status) begin
        prdata_ff <= status_ff;
      end else begin
        prdata_ff <= 32'h0000_0000;
      end
    end else begin
      prdata_ff <= 32'h0000_0000;
    end
  end

  assign prdata  = prdata_ff;
  assign pready  = pready_ff;
  assign pslverr = pslverr_ff;

  //////////////////////////////////////////////////////////////////////////
  // Error classification

  assign any_det = bit_err_det | stuff_err_det | form_err_det | crc_err_det | ack_err_det;
  // Fixed stuff bits belong to the frame format
  assign stuff_as_form = stuff_err_det & fixed_stuff_bit;
  assign stuff_real    = stuff_err_det & ~fixed_stuff_bit;
  assign form_any = form_err_det | stuff_as_form | (crc_err_det & crc_delim_err);
  assign crc_real = crc_err_det & ~crc_delim_err;

  always_comb begin
    err_set = 32'h0000_0000;
    if (tdc_phase) begin
      // Transmitter cannot tell error kinds apart here
      err_set[can_fd_err_pkg::FAST_BIT_POS] = any_det;
    end else begin
      err_set[can_fd_err_pkg::ACK_POS]        = ack_err_det;
      err_set[can_fd_err_pkg::FAST_BIT_POS]   = fast_phase & bit_err_det;
      err_set[can_fd_err_pkg::FAST_STUFF_POS] = fast_phase & stuff_real;
      err_set[can_fd_err_pkg::FAST_FORM_POS]  = fast_phase & form_any;
      err_set[can_fd_err_pkg::FAST_CRC_POS]   = fast_phase & crc_real;
      err_set[can_fd_err_pkg::NOM_BIT_POS]    = ~fast_phase & bit_err_det;
      err_set[can_fd_err_pkg::NOM_STUFF_POS]  = ~fast_phase & stuff_real;
      err_set[can_fd_err_pkg::NOM_FORM_POS]   = ~fast_phase & form_any;
      err_set[can_fd_err_pkg::NOM_CRC_POS]    = ~fast_phase & crc_real;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Error flag register

  always_comb begin
    for (int i = 0; i < 4; i++) begin
      byte_mask[i*8 +: 8] = {8{pstrb[i]}};
    end
  end

  // Write data only ever clears
  assign err_clr = (xfer_done & pwrite & hit_flags) ? (pwdata & byte_mask) : 32'h0000_0000;

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      err_flags_ff <= can_fd_err_pkg::ERR_FLAGS_RST;
    end else begin
      // Set wins over clear; flags accumulate
      err_flags_ff <= ((err_flags_ff & ~err_clr) | err_set) &
                      can_fd_err_pkg::ERR_FLAGS_MASK;
    end
  end

  assign bus_error_flags = err_flags_ff;

  //////////////////////////////////////////////////////////////////////////
  // Status register

  // Saturate rather than wrap to a misleadingly early sample point
  assign tx_delay_comp_value_sum = {1'b0, tx_delay_comp_offset} + {1'b0, tdc_measured_delay};
  assign tx_delay_comp_value     = tx_delay_comp_value_sum[7] ? can_fd_err_pkg::TX_DELAY_COMP_VALUE_MAX : tx_delay_comp_value_sum[6:0];
  assign warn     = (tx_err_count > can_fd_err_pkg::WARN_LIMIT) |
                    (rx_err_count > can_fd_err_pkg::WARN_LIMIT);

  always_comb begin
    if (config_mode) begin
      error_state_field = can_fd_err_pkg::ERROR_STATE_FIELD_CONFIG;
    end else if (bus_off) begin
      error_state_field = can_fd_err_pkg::ERROR_STATE_FIELD_BUSOFF;
    end else if (err_passive) begin
      error_state_field = can_fd_err_pkg::ERROR_STATE_FIELD_PASSIVE;
    end else begin
      error_state_field = can_fd_err_pkg::ERROR_STATE_FIELD_ACTIVE;
    end
  end

  // Read-only: bus writes never reach this register
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      status_ff <= STATUS_RST_VAL;
    end else begin
      status_ff <= 32'h0000_0000;
      status_ff[can_fd_err_pkg::TX_DELAY_COMP_VALUE_LSB +: can_fd_err_pkg::TX_DELAY_COMP_VALUE_W] <= tx_delay_comp_value;
      status_ff[can_fd_err_pkg::SNOOP_POS]  <= snoop_mode;
      status_ff[can_fd_err_pkg::NON_ISO_FORMAT_FLAG_POS]   <= non_iso_build_param;
      status_ff[can_fd_err_pkg::BSFR_POS]   <= busoff_recovery_flag;
      status_ff[can_fd_err_pkg::PEE_POS]    <= exception_integration_flag;
      status_ff[can_fd_err_pkg::ERROR_STATE_FIELD_LSB +: 2] <= error_state_field;
      status_ff[can_fd_err_pkg::WARN_POS]   <= warn;
      status_ff[can_fd_err_pkg::BUS_BUSY_FLAG_POS]   <= ~config_mode & bus_busy_flag;
      status_ff[can_fd_err_pkg::BIDLE_POS]  <= ~config_mode & ~bus_busy_flag;
      status_ff[can_fd_err_pkg::NORMAL_POS] <= normal_mode;
      status_ff[can_fd_err_pkg::SLEEP_POS]  <= sleep_mode;
      status_ff[can_fd_err_pkg::LBACK_POS]  <= loopback_mode;
      status_ff[can_fd_err_pkg::CONFIG_POS] <= config_mode;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Assertions

  property p_accum;
    @(posedge ref_clk) disable iff (rst)
    (ack_err_det & bit_err_det & ~tdc_phase & ~fast_phase) |=>
      (err_flags_ff[can_fd_err_pkg::ACK_POS] & err_flags_ff[can_fd_err_pkg::NOM_BIT_POS]);
  endproperty
  a_accum: assert property (p_accum) else $error("simultaneous errors not all flagged");

  property p_hold;
    @(posedge ref_clk) disable iff (rst)
    (err_clr == 32'h0000_0000) |=> ((~err_flags_ff & $past(err_flags_ff)) == 32'h0000_0000);
  endproperty
  a_hold: assert property (p_hold) else $error("flag dropped without clear");

  property p_no_wset;
    @(posedge ref_clk) disable iff (rst)
    (err_set == 32'h0000_0000) |=> ((err_flags_ff & ~$past(err_flags_ff)) == 32'h0000_0000);
  endproperty
  a_no_wset: assert property (p_no_wset) else $error("flag set without detection");

  property p_w1c;
    @(posedge ref_clk) disable iff (rst)
    (psel & penable & pready & pwrite & (paddr == can_fd_err_pkg::ERR_FLAGS_OFS) &
     (pstrb == 4'hf) & (err_set == 32'h0000_0000)) |=>
      ((err_flags_ff & $past(pwdata)) == 32'h0000_0000);
  endproperty
  a_w1c: assert property (p_w1c) else $error("write of one did not clear flag");

  property p_tdc;
    @(posedge ref_clk) disable iff (rst)
    (tdc_phase & crc_err_det & (err_flags_ff == 32'h0000_0000) & (err_clr == 32'h0000_0000))
      |=> (err_flags_ff == (32'h1 << can_fd_err_pkg::FAST_BIT_POS));
  endproperty
  a_tdc: assert property (p_tdc) else $error("compensation phase error not fast bit");

  property p_fixed;
    @(posedge ref_clk) disable iff (rst)
    (stuff_err_det & fixed_stuff_bit & ~tdc_phase & fast_phase & ~form_err_det &
     ~crc_err_det & ~bit_err_det & ~err_flags_ff[can_fd_err_pkg::FAST_STUFF_POS]) |=>
      (err_flags_ff[can_fd_err_pkg::FAST_FORM_POS] &
       ~err_flags_ff[can_fd_err_pkg::FAST_STUFF_POS]);
  endproperty
  a_fixed: assert property (p_fixed) else $error("fixed stuff error misfiled");

  property p_delim;
    @(posedge ref_clk) disable iff (rst)
    (crc_err_det & crc_delim_err & ~tdc_phase & ~fast_phase &
     ~err_flags_ff[can_fd_err_pkg::NOM_CRC_POS]) |=>
      (err_flags_ff[can_fd_err_pkg::NOM_FORM_POS] & ~err_flags_ff[can_fd_err_pkg::NOM_CRC_POS]);
  endproperty
  a_delim: assert property (p_delim) else $error("delimiter case set crc flag");

  property p_setwins;
    @(posedge ref_clk) disable iff (rst)
    ((err_set & err_clr) != 32'h0000_0000) |=>
      ((err_flags_ff & $past(err_set & err_clr)) == $past(err_set & err_clr));
  endproperty
  a_setwins: assert property (p_setwins) else $error("clear beat a new detection");

  property p_tx_delay_comp_value;
    @(posedge ref_clk) disable iff (rst)
    ((tx_delay_comp_offset < 7'h40) & (tdc_measured_delay < 7'h40)) |=>
      (status_ff[can_fd_err_pkg::TX_DELAY_COMP_VALUE_LSB +: can_fd_err_pkg::TX_DELAY_COMP_VALUE_W] ==
       7'($past(tx_delay_comp_offset) + $past(tdc_measured_delay)));
  endproperty
  a_tx_delay_comp_value: assert property (p_tx_delay_comp_value) else $error("compensation value wrong");

  property p_error_state_field;
    @(posedge ref_clk) disable iff (rst)
    (~config_mode & err_passive & ~bus_off) |=>
      (status_ff[can_fd_err_pkg::ERROR_STATE_FIELD_LSB +: 2] == 2'h3);
  endproperty
  a_error_state_field: assert property (p_error_state_field) else $error("passive state code wrong");

  property p_warn;
    @(posedge ref_clk) disable iff (rst)
    ((tx_err_count == 8'h61) | (rx_err_count == 8'h61)) |=> status_ff[can_fd_err_pkg::WARN_POS];
  endproperty
  a_warn: assert property (p_warn) else $error("warning missing above limit");

  property p_nowarn;
    @(posedge ref_clk) disable iff (rst)
    ((tx_err_count <= 8'h60) & (rx_err_count <= 8'h60)) |=> ~status_ff[can_fd_err_pkg::WARN_POS];
  endproperty
  a_nowarn: assert property (p_nowarn) else $error("warning set at or below limit");

  property p_cfg_reset;
    @(posedge ref_clk) disable iff (rst)
    $past(rst) |-> status_ff[can_fd_err_pkg::CONFIG_POS];
  endproperty
  a_cfg_reset: assert property (p_cfg_reset) else $error("config flag low after reset");

  property p_rsvd;
    @(posedge ref_clk) disable iff (rst)
    ((prdata & ~can_fd_err_pkg::ERR_FLAGS_MASK & 32'h0000_e000) == 32'h0000_0000) and
    ((status_ff & 32'hff80_e000) == 32'h0000_0000);
  endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved bits not zero");

  property p_ack;
    @(posedge ref_clk) disable iff (rst)
    (ack_err_det & ~tdc_phase) |=> err_flags_ff[can_fd_err_pkg::ACK_POS];
  endproperty
  a_ack: assert property (p_ack) else $error("ack error not flagged");

  property p_fast_bit;
    @(posedge ref_clk) disable iff (rst)
    (bit_err_det & fast_phase) |=> err_flags_ff[can_fd_err_pkg::FAST_BIT_POS];
  endproperty
  a_fast_bit: assert property (p_fast_bit) else $error("fast bit error not flagged");

  property p_nom_crc;
    @(posedge ref_clk) disable iff (rst)
    (crc_err_det & ~crc_delim_err & ~fast_phase & ~tdc_phase) |=>
      err_flags_ff[can_fd_err_pkg::NOM_CRC_POS];
  endproperty
  a_nom_crc: assert property (p_nom_crc) else $error("nominal crc error not flagged");

  property p_non_iso_format_flag;
    @(posedge ref_clk) disable iff (rst)
    status_ff[can_fd_err_pkg::NON_ISO_FORMAT_FLAG_POS] == non_iso_build_param;
  endproperty
  a_non_iso_format_flag: assert property (p_non_iso_format_flag) else $error("format flag differs from build");

  property p_cfg_flag;
    @(posedge ref_clk) disable iff (rst)
    config_mode |=> (status_ff[can_fd_err_pkg::CONFIG_POS] &
      (status_ff[can_fd_err_pkg::ERROR_STATE_FIELD_LSB +: 2] == can_fd_err_pkg::ERROR_STATE_FIELD_CONFIG));
  endproperty
  a_cfg_flag: assert property (p_cfg_flag) else $error("configuration not reported");

  c_w1c: cover property (@(posedge ref_clk) disable iff (rst)
    (xfer_done & pwrite & hit_flags & (err_clr != 32'h0000_0000)));
  c_setwins: cover property (@(posedge ref_clk) disable iff (rst)
    ((err_set & err_clr) != 32'h0000_0000));
  c_tdc: cover property (@(posedge ref_clk) disable iff (rst) (tdc_phase & any_det));
  c_read_status: cover property (@(posedge ref_clk) disable iff (rst)
    (xfer_done & ~pwrite & hit_status));
  c_busoff: cover property (@(posedge ref_clk) disable iff (rst)
    (~config_mode & bus_off));

endmodule

// File: inc/can_fd_err_pkg.sv
// Register map, field positions and codes for the error/status reporter
package can_fd_err_pkg;

  // Register bus geometry
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 32;

  // Byte offsets
  localparam logic [7:0] ERR_FLAGS_OFS = 8'h14;
  localparam logic [7:0] STATUS_OFS    = 8'h18;

  // Error flag bit positions
  localparam int unsigned FAST_BIT_POS   = 11;
  localparam int unsigned FAST_STUFF_POS = 10;
  localparam int unsigned FAST_FORM_POS  = 9;
  localparam int unsigned FAST_CRC_POS   = 8;
  localparam int unsigned ACK_POS        = 4;
  localparam int unsigned NOM_BIT_POS    = 3;
  localparam int unsigned NOM_STUFF_POS  = 2;
  localparam int unsigned NOM_FORM_POS   = 1;
  localparam int unsigned NOM_CRC_POS    = 0;
  localparam logic [31:0] ERR_FLAGS_MASK = 32'h0000_0f1f;
  localparam logic [31:0] ERR_FLAGS_RST  = 32'h0000_0000;

  // Status field positions
  localparam int unsigned TX_DELAY_COMP_VALUE_LSB   = 16;
  localparam int unsigned TX_DELAY_COMP_VALUE_W     = 7;
  localparam int unsigned SNOOP_POS  = 12;
  localparam int unsigned NON_ISO_FORMAT_FLAG_POS   = 11;
  localparam int unsigned BSFR_POS   = 10;
  localparam int unsigned PEE_POS    = 9;
  localparam int unsigned ERROR_STATE_FIELD_LSB  = 7;
  localparam int unsigned WARN_POS   = 6;
  localparam int unsigned BUS_BUSY_FLAG_POS   = 5;
  localparam int unsigned BIDLE_POS  = 4;
  localparam int unsigned NORMAL_POS = 3;
  localparam int unsigned SLEEP_POS  = 2;
  localparam int unsigned LBACK_POS  = 1;
  localparam int unsigned CONFIG_POS = 0;
  localparam logic [31:0] STATUS_RST = 32'h0000_0001;

  // Error state codes
  localparam logic [1:0] ERROR_STATE_FIELD_CONFIG  = 2'h0;
  localparam logic [1:0] ERROR_STATE_FIELD_ACTIVE  = 2'h1;
  localparam logic [1:0] ERROR_STATE_FIELD_PASSIVE = 2'h3;
  localparam logic [1:0] ERROR_STATE_FIELD_BUSOFF  = 2'h2;

  // Error counter warning limit
  localparam logic [7:0] WARN_LIMIT = 8'h60;
  localparam logic [6:0] TX_DELAY_COMP_VALUE_MAX   = 7'h7f;

endpackage

// File: sim/err_event_model.sv
// Protocol-engine stand-in that fires error detection pulses with their context
`timescale 1ns/1ps
module err_event_model (
  // Clock and reset
  input  wire logic       ref_clk,
  input  wire logic       rst,
  // Commands from the bench
  input  wire logic       cmd_valid,
  input  wire logic [4:0] cmd_kind,
  input  wire logic [3:0] cmd_ctx,
  // Pulses {ack,crc,form,stuff,bit} and qualifiers {fast,tdc,fixed,delim}
  output logic      [4:0] det,
  output logic      [3:0] ctx
);
  always @(posedge ref_clk) begin
    if (rst) begin
      det <= 5'h00;
      ctx <= 4'h0;
    end else if (cmd_valid) begin
      det <= cmd_kind;
      ctx <= cmd_ctx;
    end else begin
      // Qualifiers mean nothing between pulses, so keep them moving
      det <= 5'h00;
      ctx <= ~ctx;
    end
  end
endmodule

// File: sim/test_can_fd_error_status_report.sv
// Self-checking bench for the error flag and status register block
`timescale 1ns/1ps
module test_can_fd_error_status_report;
  localparam bit NON_ISO_FORMAT_FLAG = 1'b1;
  typedef struct packed {logic [31:0] data; logic err; logic rd;} note_type;
  logic        ref_clk = 1'b0;
  logic        rst = 1'b1;
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [3:0]  pstrb = 4'h0;
  logic [31:0] prdata, bus_error_flags;
  logic        pready, pslverr;
  logic        cmd_valid = 1'b0;
  logic [4:0]  cmd_kind = 5'h00, det;
  logic [3:0]  cmd_ctx = 4'h0, ctx;
  logic        cfg = 1'b1, nrm = 1'b0, snp = 1'b0, slp = 1'b0, lbk = 1'b0;
  logic        bsy = 1'b0, bsfr = 1'b0, pee = 1'b0, epas = 1'b0, boff = 1'b0;
  logic [7:0]  tec = 8'h00, rec = 8'h00;
  logic [6:0]  tofs = 7'h00, tmeas = 7'h00;
  note_type    notes[$];
  note_type    nt;
  logic [31:0] flags_exp = 32'h0;
  integer      seed = 32'h717189c6;
  int          n_fail = 0;
  int          num_checks = 0;

  always #10 ref_clk = ~ref_clk;

  can_fd_error_status_report #(.non_iso_build_param(NON_ISO_FORMAT_FLAG)) DUT (
    .ref_clk(ref_clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .bit_err_det(det[0]), .stuff_err_det(det[1]),
    .form_err_det(det[2]), .crc_err_det(det[3]), .ack_err_det(det[4]),
    .fast_phase(ctx[3]), .tdc_phase(ctx[2]), .fixed_stuff_bit(ctx[1]),
    .crc_delim_err(ctx[0]), .config_mode(cfg), .normal_mode(nrm), .snoop_mode(snp),
    .sleep_mode(slp), .loopback_mode(lbk), .bus_busy_flag(bsy),
    .busoff_recovery_flag(bsfr), .exception_integration_flag(pee),
    .err_passive(epas), .bus_off(boff), .tx_err_count(tec), .rx_err_count(rec),
    .tx_delay_comp_offset(tofs), .tdc_measured_delay(tmeas),
    .bus_error_flags(bus_error_flags));

  err_event_model partner (.ref_clk(ref_clk), .rst(rst), .cmd_valid(cmd_valid),
    .cmd_kind(cmd_kind), .cmd_ctx(cmd_ctx), .det(det), .ctx(ctx));

  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] classify(input logic [4:0] k, input logic [3:0] c);
    logic [31:0] f;
    f = 32'h0;
    if (c[2]) begin
      f[11] = |k;
    end else begin
      f[4] = k[4];
      f[c[3] ? 11 : 3] = k[0];
      f[c[3] ? 10 : 2] = k[1] & ~c[1];
      f[c[3] ? 9 : 1] = k[2] | (k[1] & c[1]) | (k[3] & c[0]);
      f[c[3] ? 8 : 0] = k[3] & ~c[0];
    end
    return f;
  endfunction

  function automatic logic [31:0] exp_status();
    logic [7:0]  sum;
    logic [31:0] s;
    sum = {1'b0, tofs} + {1'b0, tmeas};
    s = 32'h0;
    // Saturation is the designer's choice for a sum past the field
    s[22:16] = sum[7] ? 7'h7f : sum[6:0];
    s[12] = snp;
    s[11] = NON_ISO_FORMAT_FLAG;
    s[10] = bsfr;
    s[9] = pee;
    s[8:7] = cfg ? 2'h0 : boff ? 2'h2 : epas ? 2'h3 : 2'h1;
    s[6] = (tec > 8'h60) || (rec > 8'h60);
    s[5] = ~cfg & bsy;
    s[4] = ~cfg & ~bsy;
    s[3:0] = {nrm, slp, lbk, cfg};
    return s;
  endfunction

  task automatic chk_data(input logic [31:0] g, input logic [31:0] e);
    num_checks++;
    if (g !== e) begin
      n_fail++;
      $display("[ERR] %0t data got %h exp %h", $time, g, e);
    end
  endtask

  task automatic chk_view(input logic [31:0] g, input logic [31:0] e);
    num_checks++;
    if (g !== e) begin
      n_fail++;
      $display("[ERR] %0t flags got %h exp %h", $time, g, e);
    end
  endtask

  task automatic chk_resp(input logic g, input logic e);
    num_checks++;
    if (g !== e) begin
      n_fail++;
      $display("[ERR] %0t resp got %h exp %h", $time, g, e);
    end
  endtask

  task automatic tally_and_finish();
    if (n_fail == 0 && num_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // One APB transfer; race fires a queued event during the access phase
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     input logic [3:0] s, input logic [31:0] ed, input logic ee,
                     input logic race);
    int n;
    notes.push_back('{ed, ee, ~wr});
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    pstrb <= wr ? s : 4'h0;
    @(posedge ref_clk);
    penable <= 1'b1;
    cmd_valid <= race;
    n = 0;
    do begin
      @(posedge ref_clk);
      cmd_valid <= 1'b0;
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) n_fail++;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge ref_clk);
  endtask

  task automatic fire(input logic [4:0] k, input logic [3:0] c);
    cmd_kind <= k;
    cmd_ctx <= c;
    cmd_valid <= 1'b1;
    @(posedge ref_clk);
    cmd_valid <= 1'b0;
    @(posedge ref_clk);
    flags_exp = flags_exp | classify(k, c);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  always @(posedge ref_clk) begin
    if (psel && penable && pready === 1'b1) begin
      if (notes.size() == 0) begin
        n_fail++;
      end else begin
        nt = notes.pop_front();
        if (nt.rd) chk_data(prdata, nt.data);
        if (nt.rd && paddr == can_fd_err_pkg::ERR_FLAGS_OFS) chk_view(bus_error_flags, nt.data);
        chk_resp(pslverr, nt.err);
      end
    end
  end

  initial begin
    #400000;
    n_fail++;
    tally_and_finish();
  end

  initial begin
    logic [4:0]  k;
    logic [3:0]  c, s;
    logic [31:0] d, clr, nx, r;
    repeat (6) @(posedge ref_clk);
    rst <= 1'b0;
    @(posedge ref_clk);
    apb(1'b0, 8'h14, 32'h0, 4'h0, 32'h0, 1'b0, 1'b0);
    apb(1'b0, 8'h18, 32'h0, 4'h0, exp_status(), 1'b0, 1'b0);
    for (int i = 0; i < 96; i++) begin
      k = 5'($random(seed));
      c = 4'($random(seed));
      if (i % 4 == 3) begin
        d = $random(seed);
        s = 4'($random(seed));
        clr = d & {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
        if (i % 8 == 7) begin
          cmd_kind <= k;
          cmd_ctx <= c;
          nx = (flags_exp & ~clr) | classify(k, c);
          apb(1'b1, 8'h14, d, s, 32'h0, 1'b0, 1'b1);
          flags_exp = nx;
        end else begin
          apb(1'b1, 8'h14, d, s, 32'h0, 1'b0, 1'b0);
          flags_exp = flags_exp & ~clr;
        end
      end else begin
        fire(k, c);
      end
      apb(1'b0, 8'h14, 32'h0, 4'h0, flags_exp, 1'b0, 1'b0);
    end
    // Unmapped places answer with an error and leave the flags alone
    apb(1'b0, 8'h1c, 32'h0, 4'h0, 32'h0, 1'b1, 1'b0);
    apb(1'b1, 8'h20, 32'hffffffff, 4'hf, 32'h0, 1'b1, 1'b0);
    apb(1'b0, 8'h14, 32'h0, 4'h0, flags_exp, 1'b0, 1'b0);
    for (int i = 0; i < 24; i++) begin
      r = $random(seed);
      {nrm, snp, slp, lbk, bsy, bsfr, pee} <= r[6:0];
      cfg <= (i % 4 == 0);
      boff <= (i % 4 == 2);
      epas <= (i % 4 >= 2);
      tec <= (i == 1) ? 8'h60 : (i == 2) ? 8'h61 : r[15:8];
      rec <= (i == 3) ? 8'h61 : (i < 3) ? 8'h60 : r[23:16];
      tofs <= 7'($random(seed));
      tmeas <= 7'($random(seed));
      @(posedge ref_clk);
      apb(1'b1, 8'h18, 32'hffffffff, 4'hf, 32'h0, 1'b0, 1'b0);
      apb(1'b0, 8'h18, 32'h0, 4'h0, exp_status(), 1'b0, 1'b0);
    end
    tally_and_finish();
  end
endmodule
